/* rtl/scstmr_top.sv */
`timescale 1ns/1ps
module scstmr_top #(
  parameter int TICK_CYCLES  = scstmr_pkg::BASE_TICK_CYCLES,
  parameter int ABORT_CYCLES = scstmr_pkg::SEL_ABORT_CYCLES
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  pstrb,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // scsi side
  input  wire logic        scsi_request_line,
  input  wire logic        scsi_acknowledge_line,
  input  wire logic        target_mode,
  input  wire logic        select_start,
  input  wire logic        select_answered,
  // interrupt
  output logic             irq
);
  logic [7:0]  timer_period_reg_a_r;
  logic [3:0]  general_timer_code_r;
  logic [2:0]  timer_irq_status_reg_r;
  logic [2:0]  timer_irq_mask_reg_r;
  logic [2:0]  set_ev;
  logic        wr_en;
  logic        rd_en;
  logic        stat_rd;
  logic        hs_req_q_r;
  logic        hs_ack_q_r;
  logic        handshake;
  logic        hth_exp;
  logic        gen_exp;
  logic        sel_exp;
  logic        sel_run;
  logic        sel_restart;
  logic        hth_zero_r;
  logic        gen_zero_r;
  logic        sel_zero_r;
  logic        write_hth;
  logic        write_sel;
  logic        write_gen;
  logic [9:0]  addr_w;
  logic [3:0]  hth_code;
  logic [3:0]  sel_code;
  scstmr_pkg::scstmr_sel_state_t sel_state_r;
  scstmr_tick_if tk ();

  // any upper address bit set maps to an unaligned, never-decoded value
  assign addr_w  = {paddr[9:2], 2'b00} | {10{|paddr[11:10]}};
  assign wr_en   = psel && penable && pwrite && pstrb[0];
  assign rd_en   = psel && penable && !pwrite;
  assign stat_rd = rd_en && addr_w == scstmr_pkg::ADDR_IRQ_STATUS;
  assign pready  = 1'b1;

  function automatic logic addr_known(input logic [9:0] a);
    addr_known = a == scstmr_pkg::ADDR_IRQ_MASK || a == scstmr_pkg::ADDR_IRQ_STATUS ||
                 a == scstmr_pkg::ADDR_PERIODS_A || a == scstmr_pkg::ADDR_PERIOD_GEN ||
                 a == scstmr_pkg::ADDR_CTRL;
  endfunction : addr_known

  assign pslverr = psel && penable && !addr_known(addr_w);

  // register writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_period_reg_a_r <= scstmr_pkg::RST_PERIODS;
      general_timer_code_r <= scstmr_pkg::RST_PERIODS[3:0];
      timer_irq_mask_reg_r <= scstmr_pkg::RST_MASK;
    end else if (wr_en) begin
      case (addr_w)
        scstmr_pkg::ADDR_PERIODS_A:  timer_period_reg_a_r <= pwdata[7:0];
        scstmr_pkg::ADDR_PERIOD_GEN: general_timer_code_r <= pwdata[3:0];
        scstmr_pkg::ADDR_IRQ_MASK:   timer_irq_mask_reg_r <= pwdata[2:0];
        default: ;
      endcase
    end
  end

  assign hth_code  = timer_period_reg_a_r[scstmr_pkg::HTH_LSB +: 4];
  assign sel_code  = timer_period_reg_a_r[scstmr_pkg::SEL_LSB +: 4];
  assign write_hth = wr_en && addr_w == scstmr_pkg::ADDR_PERIODS_A;
  assign write_sel = write_hth;
  assign write_gen = wr_en && addr_w == scstmr_pkg::ADDR_PERIOD_GEN;

  // a rewrite only restarts after a zero was written first
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hth_zero_r <= 1'b1;
      sel_zero_r <= 1'b1;
      gen_zero_r <= 1'b1;
    end else begin
      hth_zero_r <= hth_code == 4'h0;
      sel_zero_r <= sel_code == 4'h0;
      gen_zero_r <= general_timer_code_r == 4'h0;
    end
  end

  // handshake edge: req in target mode, ack in initiator mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hs_req_q_r <= 1'b0;
      hs_ack_q_r <= 1'b0;
    end else begin
      hs_req_q_r <= scsi_request_line;
      hs_ack_q_r <= scsi_acknowledge_line;
    end
  end

  assign handshake = target_mode ? (scsi_request_line && !hs_req_q_r)
                                 : (scsi_acknowledge_line && !hs_ack_q_r);

  scstmr_prescale #(
    .TICK_CYCLES  (TICK_CYCLES),
    .ABORT_CYCLES (ABORT_CYCLES)
  ) u_pre (
    .pclk    (pclk),
    .presetn (presetn),
    .tk      (tk)
  );

  scstmr_counter u_hth (
    .pclk    (pclk),
    .presetn (presetn),
    .code    (hth_code),
    .tick    (tk.tick),
    .restart (handshake),
    .expired (hth_exp)
  );

  scstmr_counter u_gen (
    .pclk    (pclk),
    .presetn (presetn),
    .code    (general_timer_code_r),
    .tick    (tk.tick),
    .restart (1'b0),
    .expired (gen_exp)
  );

  assign sel_run     = sel_state_r == scstmr_pkg::SCSTMR_SEL_WAIT;
  assign sel_restart = !sel_run;

  scstmr_counter u_sel (
    .pclk    (pclk),
    .presetn (presetn),
    .code    (sel_code),
    .tick    (tk.tick),
    .restart (sel_restart),
    .expired (sel_exp)
  );

  // selection watch: period, then fixed abort delay
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sel_state_r <= scstmr_pkg::SCSTMR_SEL_IDLE;
    end else begin
      case (sel_state_r)
        scstmr_pkg::SCSTMR_SEL_IDLE:
          if (select_start && sel_code != 4'h0) sel_state_r <= scstmr_pkg::SCSTMR_SEL_WAIT;
        scstmr_pkg::SCSTMR_SEL_WAIT:
          if (select_answered || sel_code == 4'h0) begin
            sel_state_r <= scstmr_pkg::SCSTMR_SEL_IDLE;
          end else if (sel_exp) begin
            sel_state_r <= scstmr_pkg::SCSTMR_SEL_ABORT;
          end
        scstmr_pkg::SCSTMR_SEL_ABORT:
          if (select_answered) begin
            sel_state_r <= scstmr_pkg::SCSTMR_SEL_IDLE;
          end else if (tk.abort_done) begin
            sel_state_r <= scstmr_pkg::SCSTMR_SEL_DONE;
          end
        scstmr_pkg::SCSTMR_SEL_DONE:
          sel_state_r <= scstmr_pkg::SCSTMR_SEL_IDLE;
        default:
          sel_state_r <= scstmr_pkg::SCSTMR_SEL_IDLE;
      endcase
    end
  end

  assign tk.abort_start = sel_run && sel_exp && !select_answered;

  assign set_ev[scstmr_pkg::BIT_HANDSHAKE] = hth_exp;
  assign set_ev[scstmr_pkg::BIT_GENERAL]   = gen_exp;
  assign set_ev[scstmr_pkg::BIT_SELECT]    =
    sel_state_r == scstmr_pkg::SCSTMR_SEL_DONE;

  // sticky status: read clears reported bits, a new event wins
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_irq_status_reg_r <= scstmr_pkg::RST_STATUS;
    end else begin
      // only the bits latched for this read are cleared
      timer_irq_status_reg_r <= (timer_irq_status_reg_r & ~(stat_rd ? prdata[2:0] : 3'h0))
                                | set_ev;
    end
  end

  assign irq = |(timer_irq_status_reg_r & timer_irq_mask_reg_r);

  // read data
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (psel && !penable && !pwrite) begin
      case (addr_w)
        scstmr_pkg::ADDR_IRQ_STATUS: prdata <= {29'h0, timer_irq_status_reg_r};
        scstmr_pkg::ADDR_IRQ_MASK:   prdata <= {29'h0, timer_irq_mask_reg_r};
        scstmr_pkg::ADDR_PERIODS_A:  prdata <= {24'h0, timer_period_reg_a_r};
        scstmr_pkg::ADDR_PERIOD_GEN: prdata <= {28'h0, general_timer_code_r};
        scstmr_pkg::ADDR_CTRL:       prdata <= {29'h0, sel_state_r != scstmr_pkg::SCSTMR_SEL_IDLE,
                                                hth_zero_r, gen_zero_r};
        default:                     prdata <= 32'h0;
      endcase
    end
  end
endmodule : scstmr_top

/* rtl/scstmr_pkg.sv */
package scstmr_pkg;
  // register byte addresses (printed offsets not all multiples of four: index times four)
  localparam logic [7:0] IDX_IRQ_MASK    = 8'h41;
  localparam logic [7:0] IDX_IRQ_STATUS  = 8'h43;
  localparam logic [7:0] IDX_PERIODS_A   = 8'h48;
  localparam logic [7:0] IDX_PERIOD_GEN  = 8'h49;
  localparam logic [7:0] IDX_CTRL        = 8'h50;
  localparam logic [9:0] ADDR_IRQ_MASK   = {IDX_IRQ_MASK, 2'b00};
  localparam logic [9:0] ADDR_IRQ_STATUS = {IDX_IRQ_STATUS, 2'b00};
  localparam logic [9:0] ADDR_PERIODS_A  = {IDX_PERIODS_A, 2'b00};
  localparam logic [9:0] ADDR_PERIOD_GEN = {IDX_PERIOD_GEN, 2'b00};
  localparam logic [9:0] ADDR_CTRL       = {IDX_CTRL, 2'b00};

  // status bit positions
  localparam int BIT_HANDSHAKE = 0;
  localparam int BIT_GENERAL   = 1;
  localparam int BIT_SELECT    = 2;

  // field positions
  localparam int HTH_LSB = 4;
  localparam int SEL_LSB = 0;
  localparam int GEN_LSB = 0;

  // reset values
  localparam logic [7:0] RST_PERIODS = 8'h00;
  localparam logic [2:0] RST_STATUS  = 3'h0;
  localparam logic [2:0] RST_MASK    = 3'h0;

  // timing: base tick is 125 us at code 0001 (250 MHz scsi clock, divide setting valid)
  localparam int CLK_MHZ          = 250;
  localparam int BASE_PERIOD_US   = 125;
  localparam int SEL_ABORT_US     = 200;
  localparam int BASE_TICK_CYCLES = BASE_PERIOD_US * CLK_MHZ;
  localparam int SEL_ABORT_CYCLES = SEL_ABORT_US * CLK_MHZ;
  localparam int RD_GAP_CLKS      = 12;

  typedef enum logic [1:0] {
    SCSTMR_SEL_IDLE  = 2'b00,
    SCSTMR_SEL_WAIT  = 2'b01,
    SCSTMR_SEL_ABORT = 2'b11,
    SCSTMR_SEL_DONE  = 2'b10
  } scstmr_sel_state_t;

  // limit in base ticks for a period code; code 0 means disabled
  function automatic logic [15:0] scstmr_limit(input logic [3:0] code);
    scstmr_limit = 16'h0001 << (code - 4'h1);
  endfunction : scstmr_limit
endpackage : scstmr_pkg

/* rtl/scstmr_tick_if.sv */
`timescale 1ns/1ps
interface scstmr_tick_if;
  logic tick;
  logic abort_done;
  logic abort_start;
  modport src (output tick, output abort_done, input abort_start);
  modport dst (input tick, input abort_done, output abort_start);
endinterface : scstmr_tick_if

/* rtl/scstmr_prescale.sv */
`timescale 1ns/1ps
module scstmr_prescale #(
  parameter int TICK_CYCLES  = scstmr_pkg::BASE_TICK_CYCLES,
  parameter int ABORT_CYCLES = scstmr_pkg::SEL_ABORT_CYCLES
) (
  // clock and reset
  input wire logic      pclk,
  input wire logic      presetn,
  // tick and abort delay
  scstmr_tick_if.src    tk
);
  logic [31:0] pre_r;
  logic [31:0] abort_r;
  logic        abort_run_r;

  // base tick from the divided scsi clock rate
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_r   <= 32'h0;
      tk.tick <= 1'b0;
    end else if (pre_r == 32'(TICK_CYCLES - 1)) begin
      pre_r   <= 32'h0;
      tk.tick <= 1'b1;
    end else begin
      pre_r   <= pre_r + 32'h1;
      tk.tick <= 1'b0;
    end
  end

  // fixed selection abort delay
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      abort_r       <= 32'h0;
      abort_run_r   <= 1'b0;
      tk.abort_done <= 1'b0;
    end else if (tk.abort_start) begin
      abort_r       <= 32'h0;
      abort_run_r   <= 1'b1;
      tk.abort_done <= 1'b0;
    end else if (abort_run_r && abort_r == 32'(ABORT_CYCLES - 1)) begin
      abort_run_r   <= 1'b0;
      tk.abort_done <= 1'b1;
    end else begin
      abort_r       <= abort_run_r ? abort_r + 32'h1 : 32'h0;
      tk.abort_done <= 1'b0;
    end
  end
endmodule : scstmr_prescale

/* rtl/scstmr_counter.sv */
`timescale 1ns/1ps
module scstmr_counter (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // control
  input  wire logic [3:0] code,
  input  wire logic       tick,
  input  wire logic       restart,
  // result
  output logic            expired
);
  logic [15:0] cnt_r;
  logic        fired_r;

  // count base ticks; code 0 stops and clears
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_r   <= 16'h0;
      fired_r <= 1'b0;
      expired <= 1'b0;
    end else if (code == 4'h0 || restart) begin
      cnt_r   <= 16'h0;
      fired_r <= 1'b0;
      expired <= 1'b0;
    end else if (tick && !fired_r) begin
      if (cnt_r + 16'h1 >= scstmr_pkg::scstmr_limit(code)) begin
        fired_r <= 1'b1;
        expired <= 1'b1;
      end else begin
        expired <= 1'b0;
      end
      cnt_r <= cnt_r + 16'h1;
    end else begin
      expired <= 1'b0;
    end
  end
endmodule : scstmr_counter

/* tb/scstmr_sva.sv */
`timescale 1ns/1ps
module scstmr_sva (
  // clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // interrupt
  input wire logic        irq
);
  logic [9:0] a;
  logic       acc;
  logic       rda;
  logic       setup;
  logic       map;
  logic [2:0] mask_r;
  assign a     = paddr[11:2];
  assign acc   = psel && penable;
  assign rda   = acc && !pwrite;
  assign setup = psel && !penable;
  assign map   = a[9:8] == 2'b00 && a[7:0] inside {scstmr_pkg::IDX_IRQ_MASK,
    scstmr_pkg::IDX_IRQ_STATUS, scstmr_pkg::IDX_PERIODS_A, scstmr_pkg::IDX_PERIOD_GEN,
    scstmr_pkg::IDX_CTRL};
  // mask shadow from bus writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_r <= 3'h0;
    end else if (acc && pwrite && pstrb[0] && a == {2'b00, scstmr_pkg::IDX_IRQ_MASK}) begin
      mask_r <= pwdata[2:0];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_ready_high: assert property (psel |-> pready) else $error("pready low");
  a_err_unmapped: assert property (acc && !map |-> pslverr) else $error("no unmapped error");
  a_err_mapped: assert property (acc && map |-> !pslverr) else $error("error on mapped");
  a_err_idle: assert property (!acc |-> !pslverr) else $error("error outside access");
  a_unmapped_zero: assert property (rda && !map |-> prdata == 32'h0) else $error("bad data");
  a_status_resv:
    assert property (rda && a == {2'b00, scstmr_pkg::IDX_IRQ_STATUS} |-> prdata[31:3] == 29'h0)
      else $error("status reserved bits set");
  a_gen_resv:
    assert property (rda && a == {2'b00, scstmr_pkg::IDX_PERIOD_GEN} |-> prdata[31:4] == 28'h0)
      else $error("general reserved bits set");
  a_rdata_held:
    assert property ($changed(prdata) |-> $past(setup)) else $error("read data moved");
  a_masked_quiet:
    assert property (mask_r == 3'h0 |-> !irq) else $error("irq while all masked");
  a_reset_quiet:
    assert property ($rose(presetn) |-> !irq) else $error("irq after reset");
endmodule : scstmr_sva

/* tb/scstmr_peer.sv */
`timescale 1ns/1ps
module scstmr_peer (
  // clock and mode
  input  wire logic pclk,
  input  wire logic target_mode,
  // scsi lines
  output logic      scsi_request_line,
  output logic      scsi_acknowledge_line,
  output logic      select_answered
);
  initial begin
    scsi_request_line     = 1'b0;
    scsi_acknowledge_line = 1'b0;
    select_answered       = 1'b0;
  end
  // n handshakes, one every gap cycles, on the line the mode watches
  task automatic burst(input int n, input int gap);
    for (int i = 0; i < n; i++) begin
      if (target_mode) begin
        scsi_request_line <= 1'b1;
      end else begin
        scsi_acknowledge_line <= 1'b1;
      end
      @(posedge pclk);
      scsi_request_line     <= 1'b0;
      scsi_acknowledge_line <= 1'b0;
      repeat (gap - 1) @(posedge pclk);
    end
  endtask : burst
  // answer a selection after dly cycles
  task automatic answer(input int dly);
    repeat (dly) @(posedge pclk);
    select_answered <= 1'b1;
    repeat (4) @(posedge pclk);
    select_answered <= 1'b0;
  endtask : answer
endmodule : scstmr_peer

/* tb/tb_scsi_timeout_timers.sv */
`timescale 1ns/1ps
module tb_scsi_timeout_timers;
  localparam logic [11:0] MK = {2'b00, scstmr_pkg::ADDR_IRQ_MASK};
  localparam logic [11:0] ST = {2'b00, scstmr_pkg::ADDR_IRQ_STATUS};
  localparam logic [11:0] PA = {2'b00, scstmr_pkg::ADDR_PERIODS_A};
  localparam logic [11:0] PG = {2'b00, scstmr_pkg::ADDR_PERIOD_GEN};
  localparam logic [11:0] CT = {2'b00, scstmr_pkg::ADDR_CTRL};
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic        target_mode, select_start, req, ack, ans, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb;
  int          miscompares, checks;
  scstmr_top #(.TICK_CYCLES(10), .ABORT_CYCLES(20)) dut_u (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .scsi_request_line(req), .scsi_acknowledge_line(ack),
    .target_mode(target_mode), .select_start(select_start), .select_answered(ans), .irq(irq));
  scstmr_peer peer_u (.pclk(pclk), .target_mode(target_mode), .scsi_request_line(req),
    .scsi_acknowledge_line(ack), .select_answered(ans));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : xfer
  task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk(nm, rd, exp);
  endtask : rdc
  task automatic final_report();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : final_report
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  initial begin
    repeat (20000) @(posedge pclk);
    miscompares++;
    final_report();
  end
  initial begin
    {presetn, psel, penable, pwrite, target_mode, select_start} = 6'h00;
    paddr  = 12'h000;
    pwdata = 32'h0;
    pstrb  = 4'hf;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc("periods_a", PA, 32'h0);
    chk("pslverr_mapped", {31'h0, er}, 32'h0);
    rdc("ctrl", CT, 32'h3);
    rdc("period_gen", PG, 32'h0);
    rdc("status", ST, 32'h0);
    rdc("mask", MK, 32'h0);
    rdc("unmapped", 12'h000, 32'h0);
    chk("pslverr_unmapped", {31'h0, er}, 32'h1);
    pstrb <= 4'he;
    xfer(1'b1, PA, 32'h55);
    pstrb <= 4'hf;
    rdc("strobe_off", PA, 32'h0);
    xfer(1'b1, PA, 32'h21);
    rdc("periods_a", PA, 32'h21);
    xfer(1'b1, PA, 32'h0);
    $display("test registers done");
    xfer(1'b1, PG, 32'h1);
    repeat (20) @(posedge pclk);
    chk("irq_masked", {31'h0, irq}, 32'h0);
    rdc("status_gen", ST, 32'h2);
    repeat (12) @(posedge pclk);
    rdc("status_clr", ST, 32'h0);
    xfer(1'b1, PG, 32'h0);
    xfer(1'b1, MK, 32'h2);
    xfer(1'b1, PG, 32'h3);
    repeat (22) @(posedge pclk);
    rdc("gen_early", ST, 32'h0);
    repeat (25) @(posedge pclk);
    chk("irq_gen", {31'h0, irq}, 32'h1);
    rdc("gen_late", ST, 32'h2);
    chk("irq_clr", {31'h0, irq}, 32'h0);
    xfer(1'b1, PG, 32'h0);
    $display("test general timer done");
    xfer(1'b1, MK, 32'h7);
    for (int m = 1; m >= 0; m--) begin
      target_mode <= m[0];
      xfer(1'b1, PA, 32'h20);
      peer_u.burst(8, 6);
      chk("irq_hs", {31'h0, irq}, 32'h0);
      rdc("hs_early", ST, 32'h0);
      repeat (30) @(posedge pclk);
      chk("irq_hs", {31'h0, irq}, 32'h1);
      rdc("hs_late", ST, 32'h1);
      xfer(1'b1, PA, 32'h0);
      repeat (12) @(posedge pclk);
    end
    $display("test handshake done");
    xfer(1'b1, PA, 32'h1);
    select_start <= 1'b1;
    @(posedge pclk);
    select_start <= 1'b0;
    peer_u.answer(3);
    repeat (50) @(posedge pclk);
    rdc("sel_answered", ST, 32'h0);
    select_start <= 1'b1;
    @(posedge pclk);
    select_start <= 1'b0;
    repeat (12) @(posedge pclk);
    rdc("sel_early", ST, 32'h0);
    repeat (30) @(posedge pclk);
    chk("irq_sel", {31'h0, irq}, 32'h1);
    rdc("sel_late", ST, 32'h4);
    $display("test selection done");
    final_report();
  end
endmodule : tb_scsi_timeout_timers
bind scstmr_top scstmr_sva chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));
